// ===== bench/service_host.sv
// Purpose: Host side issuing service requests
// Assumes: One request at a time
// Notes: Idle opcode, LBA and parameter are inverted so stale values never pass as held
`timescale 1ns/1ns
module service_host (
	// Clock
	input wire CLK_SYS,
	// Request
	output logic REQ_VALID = 1'b0,
	output logic REQ_IS_SECTOR = 1'b0,
	output logic [7:0] REQ_OPCODE = 8'h00,
	output logic [27:0] REQ_LBA = 28'h000_0000,
	output logic [1:0] REQ_PARAM = 2'h0
);
	task req(input logic sec, input logic [3:0] svc, input logic [1:0] prm);
		@(posedge CLK_SYS) #5;
		REQ_VALID = 1'b1;
		REQ_IS_SECTOR = sec;
		REQ_OPCODE = 8'hF0 + {4'h0, svc};
		REQ_LBA = {20'h0_FFFF, 4'h0, svc};
		REQ_PARAM = prm;
		@(posedge CLK_SYS) #5;
		REQ_VALID = 1'b0;
		REQ_OPCODE = ~REQ_OPCODE;
		REQ_LBA = ~REQ_LBA;
		REQ_PARAM = ~REQ_PARAM;
	endtask
endmodule // service_host

// ===== bench/service_role_dispatcher_checker.sv
// Purpose: Timing relations of the dispatcher's control outputs
// Assumes: One clock domain, RST async high
// Notes: Sees only top-level ports
`timescale 1ns/1ns
`include "service_dispatch_defines.vh"
module service_role_dispatcher_checker (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST,
	// Request and events
	input wire REQ_VALID,
	input wire POWER_CHANGE,
	// Answer and control
	input wire RESP_VALID,
	input wire [1:0] REQ_STATUS,
	input wire [2:0] HANDLER_ROLE,
	input wire SHUTDOWN_STATE,
	input wire LOW_POWER,
	input wire SANITIZE,
	input wire SELF_TEST_RUN
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	property p_answer;
		RESP_VALID |-> $past(REQ_VALID);
	endproperty
	a_answer: assert property (p_answer) else $error("answer without request");
	property p_refuse_quiet;
		RESP_VALID && REQ_STATUS == `REQ_REFUSED |-> !$rose(SHUTDOWN_STATE) && !$rose(SELF_TEST_RUN);
	endproperty
	a_refuse_quiet: assert property (p_refuse_quiet) else $error("refusal had effect");
	property p_restart_gate;
		$rose(SELF_TEST_RUN) |-> $past(HANDLER_ROLE) == `ROLE_NONE;
	endproperty
	a_restart_gate: assert property (p_restart_gate) else $error("restart from a role");
	property p_test_roles;
		SELF_TEST_RUN |-> HANDLER_ROLE == `ROLE_NONE;
	endproperty
	a_test_roles: assert property (p_test_roles) else $error("role during self test");
	property p_shut_roles;
		SHUTDOWN_STATE |-> HANDLER_ROLE == `ROLE_NONE && LOW_POWER;
	endproperty
	a_shut_roles: assert property (p_shut_roles) else $error("shutdown keeps role");
	property p_shut_hold;
		SHUTDOWN_STATE |=> SHUTDOWN_STATE;
	endproperty
	a_shut_hold: assert property (p_shut_hold) else $error("shutdown left");
	property p_power;
		POWER_CHANGE |=> SHUTDOWN_STATE;
	endproperty
	a_power: assert property (p_power) else $error("power change ignored");
	property p_sanitize;
		$rose(SHUTDOWN_STATE) |-> SANITIZE;
	endproperty
	a_sanitize: assert property (p_sanitize) else $error("no sanitize");
endmodule // service_role_dispatcher_checker
bind service_role_dispatcher service_role_dispatcher_checker chk_i (.CLK_SYS, .RST, .REQ_VALID,
	.POWER_CHANGE, .RESP_VALID, .REQ_STATUS, .HANDLER_ROLE, .SHUTDOWN_STATE, .LOW_POWER,
	.SANITIZE, .SELF_TEST_RUN);

// ===== bench/service_role_dispatcher_tb.sv
// Purpose: Scenario bench for the dispatcher
// Assumes: Answer visible 5 ns after the taken edge
// Notes: Self test wait padded past 65 cycles
`timescale 1ns/1ns
module service_role_dispatcher_tb;
	logic clk_sys = 0, rst = 1, pwr = 0, ishut = 0, aset = 0, eset = 0, bset = 0, bto = 0;
	logic lv = 0, stf = 0;
	logic [2:0] lrole = 0;
	logic [6:0] lid = 0;
	logic [15:0] dident = 16'hA5C3;
	wire rv, isec, dpa, shut, lp, san, str, alm, err, blk, vld;
	wire [1:0] st, prm;
	wire [2:0] role;
	wire [7:0] opc;
	wire [27:0] lba;
	wire [31:0] rd;
	int n_fail = 0, comparisons = 0, cyc = 0;
	service_host h (.CLK_SYS(clk_sys), .REQ_VALID(vld), .REQ_IS_SECTOR(isec), .REQ_OPCODE(opc),
		.REQ_LBA(lba), .REQ_PARAM(prm));
	service_role_dispatcher dut (.CLK_SYS(clk_sys), .RST(rst), .REQ_VALID(vld),
		.REQ_IS_SECTOR(isec), .REQ_OPCODE(opc), .REQ_LBA(lba), .REQ_PARAM(prm),
		.POWER_CHANGE(pwr), .INTERNAL_SHUTDOWN(ishut), .ALARM_SET(aset), .ERROR_SET(eset),
		.BLOCKER_SET(bset), .BLOCKER_TIMEOUT(bto), .LOGIN_VALID(lv), .LOGIN_ROLE(lrole),
		.LOGIN_ID(lid), .SELF_TEST_FAIL(stf), .DRIVE_IDENT(dident), .RESP_VALID(rv),
		.REQ_STATUS(st), .RESP_DATA(rd), .HANDLER_ROLE(role), .DATAPATH_ACTIVE(dpa),
		.SHUTDOWN_STATE(shut), .LOW_POWER(lp), .SANITIZE(san), .SELF_TEST_RUN(str),
		.ALARM(alm), .ERROR(err), .BLOCKER(blk));
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys) #5;
	endtask
	task close_out;
		$display("comparisons %0d failures %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task do_reset;
		rst = 1;
		tick(16);
		rst = 0;
		tick(1);
		chk({str, role, dpa, shut, rv}, 7'h40);
		h.req(0, 7, 0);
		chk(rv, 1'b0);
		tick(68);
	endtask
	task t_drive;
		h.req(0, 8, 0);
		chk({rv, st}, 3'h5);
		chk(rd, {16'h0, dident});
		dident = 16'h3C5A;
		h.req(1, 8, 0);
		chk({rv, st}, 3'h5);
		chk(rd, 32'h0000_3C5A);
	endtask
	task t_restart;
		eset = 1;
		tick(1);
		eset = 0;
		h.req(0, 3, 0);
		chk({st, err, str, role}, 7'h28);
		tick(70);
		chk({str, role}, 4'h0);
	endtask
	task t_flags;
		aset = 1;
		bset = 1;
		tick(1);
		aset = 0;
		bset = 0;
		h.req(1, 2, 0);
		chk({st, alm, str, shut}, 5'h08);
		h.req(0, 6, 0);
		chk({st, blk}, 3'h5);
		lv = 1;
		lrole = 3;
		tick(1);
		lv = 0;
		chk(role, 3'h0);
		bto = 1;
		h.req(0, 6, 0);
		chk({st, blk}, 3'h2);
	endtask
	task t_roles;
		lv = 1;
		lrole = 2;
		lid = 5;
		tick(1);
		lv = 0;
		tick(1);
		chk({role, dpa}, 4'h5);
		for (int s = 2; s < 7; s++) begin
			h.req(0, s[3:0], 1);
			chk({rv, st, role, shut, str}, 8'hC8);
		end
		h.req(0, 7, 0);
		chk(st, 2'h1);
		chk(rd, 32'h0000_02A8);
		pwr = 1;
		tick(1);
		pwr = 0;
		tick(1);
		chk({shut, lp, role, dpa}, 6'h30);
	endtask
	task t_paths;
		aset = 1;
		tick(1);
		aset = 0;
		h.req(0, 2, 1);
		chk({st, alm, str, shut}, 5'h0A);
		tick(70);
		ishut = 1;
		tick(1);
		ishut = 0;
		chk({shut, lp, san}, 3'h7);
		do_reset;
		eset = 1;
		tick(1);
		eset = 0;
		h.req(1, 3, 1);
		chk({st, err, shut, san}, 5'h0B);
		do_reset;
		aset = 1;
		tick(1);
		aset = 0;
		h.req(0, 2, 2);
		chk({st, alm, shut}, 4'h5);
		do_reset;
		lv = 1;
		lrole = 4;
		lid = 9;
		tick(1);
		lv = 0;
		chk({role, dpa}, 4'h9);
		h.req(0, 1, 0);
		chk({st, shut, role, dpa}, 7'h30);
	endtask
	task t_force;
		h.req(0, 7, 0);
		chk(rd, 32'h0002_0000);
		h.req(0, 4, 0);
		chk({st, shut}, 3'h3);
		tick(1);
		chk({shut, lp}, 2'h3);
	endtask
	initial begin
		do_reset;
		t_drive;
		t_restart;
		t_flags;
		t_roles;
		do_reset;
		t_paths;
		stf = 1;
		do_reset;
		stf = 0;
		t_force;
		close_out;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			close_out;
		end
	end
endmodule // service_role_dispatcher_tb

// ===== src/service_decode.v
// Purpose: Maps a vendor command or reserved sector access to a service code
// Assumes: Command fields valid in the strobe cycle
// Notes: Unknown requests give the empty service code
`timescale 1ns/1ns
`include "service_dispatch_defines.vh"
module service_decode (
	input wire is_sector,
	input wire [7:0] opcode,
	input wire [27:0] lba,
	output reg [3:0] svc
);
	reg [7:0] idx;
	always @* begin
		idx = is_sector ? lba[7:0] : (opcode - `CMD_VENDOR_BASE);
		svc = `SVC_NONE;
		if (is_sector && {lba[27:8], 8'h00} != `SECTOR_SVC_BASE)
			svc = `SVC_NONE;
		else if (!is_sector && opcode < `CMD_VENDOR_BASE)
			svc = `SVC_NONE;
		else if (idx >= 8'h01 && idx <= 8'h08)
			svc = idx[3:0];
	end
endmodule // service_decode

// ===== src/service_dispatch_defines.vh
// Purpose: Constants for the service role dispatcher
// Assumes: Included by the dispatcher and its decoder
// Notes: Service and role codes are internal encodings
`ifndef SERVICE_DISPATCH_DEFINES_VH
`define SERVICE_DISPATCH_DEFINES_VH
// Roles
`define ROLE_NONE 3'h0
`define ROLE_INITIATOR 3'h1
`define ROLE_OFFICER 3'h2
`define ROLE_MANAGER 3'h3
`define ROLE_USER 3'h4
// Service codes
`define SVC_NONE 4'h0
`define SVC_SHUTDOWN 4'h1
`define SVC_CLR_ALARM 4'h2
`define SVC_CLR_ERROR 4'h3
`define SVC_FORCE_SHUT 4'h4
`define SVC_RESTART 4'h5
`define SVC_CLR_BLOCKER 4'h6
`define SVC_CORE_STATUS 4'h7
`define SVC_DRIVE_STATUS 4'h8
// Vendor command opcodes and reserved sector addresses
`define CMD_VENDOR_BASE 8'hF0
`define SECTOR_SVC_BASE 28'h0FF_FF00
// Clear-alarm parameter values
`define ALARM_TO_READY 2'h0
`define ALARM_TO_RESTART 2'h1
`define ALARM_TO_SHUTDOWN 2'h2
// Request status codes
`define REQ_IDLE 2'h0
`define REQ_DONE 2'h1
`define REQ_REFUSED 2'h2
// Self test length in cycles
`define SELF_TEST_CYCLES 8'h40
`endif

// ===== src/service_role_dispatcher.v
// Purpose: Checks service requests against the handler role and runs control services
// Assumes: Host request strobes synchronous to CLK_SYS
// Notes: Login and account logic sit outside and drive role changes in
// Operation
// - Host requests come as vendor commands or reserved sector accesses; both decoded.
// - A request runs only if permitted in the handler's current role.
// - Shutdown comes from power change or another service, any role.
// - Shutdown enters shutdown state, low power, sanitize, both roles to none.
// - Clear alarm only in no role; then ready, restart or shutdown.
// - Clear error only in no role; then restart or shutdown.
// - Force shutdown only in no role; always starts shutdown.
// - Restart only in no role; roles to none, self tests run.
// - Clear blocker only in no role, blocker active and timeout expired.
// - Core status in every role: tests, error, operator, role, request status.
// - Drive status in every role: drive identify data returned.
// - After power-up or restart both handler and datapath hold no role.
`timescale 1ns/1ns
`include "service_dispatch_defines.vh"
module service_role_dispatcher (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST,
	// Host request
	input wire REQ_VALID,
	input wire REQ_IS_SECTOR,
	input wire [7:0] REQ_OPCODE,
	input wire [27:0] REQ_LBA,
	input wire [1:0] REQ_PARAM,
	// Events and state from the rest of the module
	input wire POWER_CHANGE,
	input wire INTERNAL_SHUTDOWN,
	input wire ALARM_SET,
	input wire ERROR_SET,
	input wire BLOCKER_SET,
	input wire BLOCKER_TIMEOUT,
	input wire LOGIN_VALID,
	input wire [2:0] LOGIN_ROLE,
	input wire [6:0] LOGIN_ID,
	input wire SELF_TEST_FAIL,
	input wire [15:0] DRIVE_IDENT,
	// Answer
	output reg RESP_VALID,
	output reg [1:0] REQ_STATUS,
	output reg [31:0] RESP_DATA,
	// Control outputs
	output reg [2:0] HANDLER_ROLE,
	output reg DATAPATH_ACTIVE,
	output reg SHUTDOWN_STATE,
	output reg LOW_POWER,
	output reg SANITIZE,
	output reg SELF_TEST_RUN,
	output reg ALARM,
	output reg ERROR,
	output reg BLOCKER
);
	localparam ST_READY = 2'h0;
	localparam ST_TEST = 2'h1;
	localparam ST_SHUT = 2'h2;

	wire [3:0] svc;
	reg [1:0] state_r, state_nxt;
	reg [7:0] test_cnt_r;
	reg [6:0] op_id_r;
	reg test_fail_r;
	reg allowed;
	reg go_shut, go_restart;

	service_decode u_decode (
		.is_sector(REQ_IS_SECTOR),
		.opcode(REQ_OPCODE),
		.lba(REQ_LBA),
		.svc(svc)
	);

	wire no_role = (HANDLER_ROLE == `ROLE_NONE);
	// Requests during self test or shutdown are dropped without an answer
	wire req_ok = REQ_VALID && (svc != `SVC_NONE) && (state_r == ST_READY);

	// Role gate: only shutdown and status services are open to a logged-in role
	always @* begin
		case (svc)
			`SVC_SHUTDOWN, `SVC_CORE_STATUS, `SVC_DRIVE_STATUS:
				allowed = 1'b1;
			`SVC_CLR_ALARM, `SVC_CLR_ERROR, `SVC_FORCE_SHUT, `SVC_RESTART:
				allowed = no_role;
			`SVC_CLR_BLOCKER:
				allowed = no_role && BLOCKER && BLOCKER_TIMEOUT;
			default:
				allowed = 1'b0;
		endcase
	end

	wire run = req_ok && allowed;

	// Sticky flags, bit 0 alarm, bit 1 error, bit 2 blocker
	wire clr_alarm = run && (svc == `SVC_CLR_ALARM);
	wire clr_error = run && (svc == `SVC_CLR_ERROR);
	wire clr_blocker = run && (svc == `SVC_CLR_BLOCKER);
	wire [2:0] flag_set = {BLOCKER_SET, ERROR_SET, ALARM_SET};
	wire [2:0] flag_clr = {clr_blocker, clr_error, clr_alarm};
	wire [2:0] flag_now = {BLOCKER, ERROR, ALARM};
	wire [2:0] flag_nxt;
	genvar gi;

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
			// A set in the clearing cycle wins so a fresh fault is never lost
			assign flag_nxt[gi] = flag_set[gi] | (flag_now[gi] & ~flag_clr[gi]);
		end
	endgenerate

	// Core status word, low to high: spare, test running, previous status, role,
	// operator, blocker, alarm, error, test failed, then zero fill
	wire [31:0] core_word = {14'h0000, test_fail_r, ERROR, ALARM, BLOCKER, op_id_r,
		HANDLER_ROLE, REQ_STATUS, SELF_TEST_RUN, 1'b0};

	// Login is held off while the response blocker is up
	wire login_take = LOGIN_VALID && !BLOCKER;

	// Follow-on action of each system-control service
	always @* begin
		go_shut = POWER_CHANGE || INTERNAL_SHUTDOWN;
		go_restart = 1'b0;
		if (run) begin
			case (svc)
				`SVC_SHUTDOWN, `SVC_FORCE_SHUT: go_shut = 1'b1;
				`SVC_CLR_ALARM: begin
					if (REQ_PARAM == `ALARM_TO_RESTART)
						go_restart = 1'b1;
					else if (REQ_PARAM == `ALARM_TO_SHUTDOWN)
						go_shut = 1'b1;
				end
				`SVC_CLR_ERROR: begin
					if (REQ_PARAM[0])
						go_shut = 1'b1;
					else
						go_restart = 1'b1;
				end
				`SVC_RESTART: go_restart = 1'b1;
				default: ;
			endcase
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_READY: begin
				// Shutdown outranks restart when both are asked at once
				if (go_shut)
					state_nxt = ST_SHUT;
				else if (go_restart)
					state_nxt = ST_TEST;
			end
			ST_TEST: begin
				// A shutdown beats the running self test
				if (go_shut)
					state_nxt = ST_SHUT;
				else if (test_cnt_r == 8'h00)
					state_nxt = ST_READY;
			end
			// Shutdown is left only by reset, like a removed supply
			ST_SHUT: state_nxt = ST_SHUT;
			default: state_nxt = ST_READY;
		endcase
	end

	// Self test counter runs down to zero, one step per cycle
	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_r <= ST_TEST;
			test_cnt_r <= `SELF_TEST_CYCLES;
			test_fail_r <= 1'b0;
			op_id_r <= 7'h00;
			HANDLER_ROLE <= `ROLE_NONE;
			DATAPATH_ACTIVE <= 1'b0;
			SHUTDOWN_STATE <= 1'b0;
			LOW_POWER <= 1'b0;
			SANITIZE <= 1'b0;
			SELF_TEST_RUN <= 1'b1;
			ALARM <= 1'b0;
			ERROR <= 1'b0;
			BLOCKER <= 1'b0;
			RESP_VALID <= 1'b0;
			REQ_STATUS <= `REQ_IDLE;
			RESP_DATA <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			if (state_nxt == ST_TEST && state_r != ST_TEST) begin
				test_cnt_r <= `SELF_TEST_CYCLES;
				test_fail_r <= 1'b0;
			end else if (state_r == ST_TEST && test_cnt_r != 8'h00) begin
				test_cnt_r <= test_cnt_r - 8'h01;
				test_fail_r <= test_fail_r | SELF_TEST_FAIL;
			end
			SELF_TEST_RUN <= (state_nxt == ST_TEST);
			SHUTDOWN_STATE <= (state_nxt == ST_SHUT);
			LOW_POWER <= (state_nxt == ST_SHUT);
			// Sanitize is one pulse on entry so the wipe runs once
			SANITIZE <= (state_nxt == ST_SHUT) && (state_r != ST_SHUT);
			if (state_nxt != ST_READY) begin
				HANDLER_ROLE <= `ROLE_NONE;
				DATAPATH_ACTIVE <= 1'b0;
			end else if (login_take) begin
				HANDLER_ROLE <= LOGIN_ROLE;
				op_id_r <= LOGIN_ID;
				// The initiator never takes a datapath role
				DATAPATH_ACTIVE <= (LOGIN_ROLE != `ROLE_INITIATOR) &&
					(LOGIN_ROLE != `ROLE_NONE);
			end
			ALARM <= flag_nxt[0];
			ERROR <= flag_nxt[1];
			BLOCKER <= flag_nxt[2];
			RESP_VALID <= req_ok;
			if (req_ok)
				REQ_STATUS <= run ? `REQ_DONE : `REQ_REFUSED;
			if (run && svc == `SVC_CORE_STATUS)
				RESP_DATA <= core_word;
			else if (run && svc == `SVC_DRIVE_STATUS)
				RESP_DATA <= {16'h0000, DRIVE_IDENT};
			else if (req_ok)
				RESP_DATA <= 32'h0000_0000;
		end
	end
endmodule // service_role_dispatcher
